// ---- core/bfpl_pkg.sv ----
// Shared constants, types and structures of the battery fault priority logic
package bfpl_pkg;

	// Default delay counts in clock cycles (simulation shortens them via parameters)
	localparam int unsigned BFPL_CNT_W        = 16;
	localparam logic [15:0] BFPL_OVC_DLY      = 16'h0064;
	localparam logic [15:0] BFPL_OVD_DLY      = 16'h0064;
	localparam logic [15:0] BFPL_OCR_DLY      = 16'h0032;
	localparam logic [15:0] BFPL_SCD_DLY      = 16'h0004;
	localparam logic [15:0] BFPL_XCH_DLY      = 16'h0032;
	localparam logic [15:0] BFPL_REL_DLY      = 16'h0010;

	// Who was established first
	typedef enum logic [1:0] {
		BFPL_FIRST_NONE = 2'h0,
		BFPL_FIRST_OCR  = 2'h1,
		BFPL_FIRST_OTHR = 2'h2
	} bfpl_first_t;

	// Sense node bias control
	typedef enum logic [2:0] {
		BFPL_BIAS_OPEN = 3'h1,
		BFPL_BIAS_GND  = 3'h2,
		BFPL_BIAS_SUP  = 3'h4
	} bfpl_bias_t;

	// Raw comparator levels from the analog front end
	typedef struct packed {
		logic over_charge;
		logic over_discharge;
		logic over_current;
		logic short_circuit;
		logic excess_charger;
	} bfpl_cmp_t;

	// Established fault states
	typedef struct packed {
		logic over_charge;
		logic over_discharge;
		logic over_current;
		logic short_circuit;
		logic excess_charger;
	} bfpl_state_t;

endpackage : bfpl_pkg

// ---- core/bfpl_delay.sv ----
// Qualifying delay counter: output follows input after a stable run
`timescale 1ns/10ps
module bfpl_delay #(
	parameter int unsigned   W     = 16,
	parameter logic [15:0]   SET   = 16'h0010,
	parameter logic [15:0]   CLR   = 16'h0010
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        cond,
	input  wire logic        hold,
	input  wire logic        abort,
	output logic             state,
	output logic             busy
);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;
	logic         state_reg;
	logic         state_next;

	// Count while the condition differs from the state; hold freezes, abort restarts
	always_comb begin
		cnt_next   = cnt_reg;
		state_next = state_reg;
		if (abort || (cond == state_reg)) begin
			cnt_next = '0;
		end else if (!hold) begin
			if (cnt_reg >= (state_reg ? CLR[W-1:0] : SET[W-1:0]) - W'(1)) begin
				state_next = cond;
				cnt_next   = '0;
			end else begin
				cnt_next = cnt_reg + W'(1);
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cnt_reg   <= '0;
			state_reg <= 1'b0;
		end else begin
			cnt_reg   <= cnt_next;
			state_reg <= state_next;
		end
	end

	assign state = state_reg;
	assign busy  = (cond != state_reg) && !abort;
endmodule : bfpl_delay

// ---- core/bfpl_first.sv ----
// Order recorder: notes which of two states was established first
`timescale 1ns/10ps
module bfpl_first
	import bfpl_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        ocr_state,
	input  wire logic        oth_state,
	output bfpl_pkg::bfpl_first_t first
);
	bfpl_first_t first_reg;
	bfpl_first_t first_next;

	// A lone state counts as first; a dropped over-current hands the lead to the other state
	always_comb begin
		first_next = first_reg;
		if (!ocr_state) begin
			first_next = oth_state ? BFPL_FIRST_OTHR : BFPL_FIRST_NONE;
		end else if (!oth_state) begin
			first_next = BFPL_FIRST_OCR;
		end else if (first_reg == BFPL_FIRST_NONE) begin
			first_next = BFPL_FIRST_OTHR; // Same edge: the other state wins
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			first_reg <= BFPL_FIRST_NONE;
		end else begin
			first_reg <= first_next;
		end
	end

	assign first = first_reg;
endmodule : bfpl_first

// ---- core/bfpl_core.sv ----
// Top of the battery fault priority logic
//
// What this block does
// - Over-charge and over-current run in parallel; over-current never resets over-charge.
// - Over-charge established first interrupts any over-current detection in progress.
// - Over-charge detection starting suspends over-discharge detection.
// - After over-charge is established, over-discharge detection resumes from its held count if still present.
// - Over-discharge after over-charge: no standby, sense node pulled to supply.
// - Over-discharge and over-current run concurrently; over-current first never halts it.
// - Over-discharge established first abandons over-current detection.
// - Over-current then over-discharge: drop ground pull, apply supply pull, enter standby.
// - Over-discharge before over-current: supply pull-up and standby.
// - Over-charge with over-current: ground pull if over-current first, else released.
// - Short-circuit detection is independent of every other state.
// - Excessive-charger detection inhibited during over-discharge, over-current or short.
// - Excessive-charger delay starts only after discharge gate returned high.
// - Over-current or short drives discharge gate low after its delay.
// - Excessive charger drives charge gate low after delay, high after the same XCH_DLY delay on release.
`timescale 1ns/10ps
module bfpl_core
	import bfpl_pkg::*;
#(
	parameter logic [15:0] OVC_DLY = BFPL_OVC_DLY,
	parameter logic [15:0] OVD_DLY = BFPL_OVD_DLY,
	parameter logic [15:0] OCR_DLY = BFPL_OCR_DLY,
	parameter logic [15:0] SCD_DLY = BFPL_SCD_DLY,
	parameter logic [15:0] XCH_DLY = BFPL_XCH_DLY,
	parameter logic [15:0] REL_DLY = BFPL_REL_DLY
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  bfpl_pkg::bfpl_cmp_t    cmp,
	output bfpl_pkg::bfpl_state_t  fault,
	output logic                   dis_gate,
	output logic                   chg_gate,
	output bfpl_pkg::bfpl_bias_t   sense_bias,
	output logic                   standby
);
	import bfpl_pkg::*;

	logic        ovc_st, ovd_st, ocr_st, scd_st, xch_st;
	logic        ovc_busy, ovd_busy, ocr_busy, scd_busy, xch_busy;
	logic        ovd_hold, ocr_abort, xch_abort;
	bfpl_first_t first_ovc;
	bfpl_first_t first_ovd;

	logic        dis_gate_reg, dis_gate_next;
	logic        chg_gate_reg, chg_gate_next;
	logic        standby_reg, standby_next;
	logic        ovc_seen_reg, ovc_seen_next;
	bfpl_bias_t  bias_reg, bias_next;
	bfpl_state_t fault_reg, fault_next;

	// Over-discharge waits while over-charge is being qualified
	// It resumes from its held count once over-charge is settled
	assign ovd_hold = ovc_busy && !ovc_st;

	// Over-current gives way to whichever other state came first
	// Never aborts an established over-current, so its release can still count
	assign ocr_abort = !ocr_st &&
	                   ((ovc_st && first_ovc != BFPL_FIRST_OCR) ||
	                    (ovd_st && first_ovd != BFPL_FIRST_OCR));

	// Excessive charger held off during over-discharge, over-current or short and until discharge gate is high
	assign xch_abort = ovd_st || ocr_st || scd_st || !dis_gate_reg;

	// Over-charge: never touched by over-current
	bfpl_delay #(.W(BFPL_CNT_W), .SET(OVC_DLY), .CLR(REL_DLY)) u_ovc (
		.sys_clk (sys_clk),
		.rst     (rst),
		.cond    (cmp.over_charge),
		.hold    (1'b0),
		.abort   (1'b0),
		.state   (ovc_st),
		.busy    (ovc_busy)
	);

	// Over-discharge: over-current does not stop it
	bfpl_delay #(.W(BFPL_CNT_W), .SET(OVD_DLY), .CLR(REL_DLY)) u_ovd (
		.sys_clk (sys_clk),
		.rst     (rst),
		.cond    (cmp.over_discharge),
		.hold    (ovd_hold),
		.abort   (1'b0),
		.state   (ovd_st),
		.busy    (ovd_busy)
	);

	// Over-current qualifier
	bfpl_delay #(.W(BFPL_CNT_W), .SET(OCR_DLY), .CLR(REL_DLY)) u_ocr (
		.sys_clk (sys_clk),
		.rst     (rst),
		.cond    (cmp.over_current),
		.hold    (1'b0),
		.abort   (ocr_abort),
		.state   (ocr_st),
		.busy    (ocr_busy)
	);

	// Short circuit runs alone, no hold nor abort
	bfpl_delay #(.W(BFPL_CNT_W), .SET(SCD_DLY), .CLR(REL_DLY)) u_scd (
		.sys_clk (sys_clk),
		.rst     (rst),
		.cond    (cmp.short_circuit),
		.hold    (1'b0),
		.abort   (1'b0),
		.state   (scd_st),
		.busy    (scd_busy)
	);

	// Excessive charger, detect and release both delayed
	bfpl_delay #(.W(BFPL_CNT_W), .SET(XCH_DLY), .CLR(XCH_DLY)) u_xch (
		.sys_clk (sys_clk),
		.rst     (rst),
		.cond    (cmp.excess_charger),
		.hold    (1'b0),
		.abort   (xch_abort && !xch_st),
		.state   (xch_st),
		.busy    (xch_busy)
	);

	// Order of over-current versus over-charge, and versus over-discharge
	bfpl_first u_first_ovc (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.ocr_state (ocr_st),
		.oth_state (ovc_st),
		.first     (first_ovc)
	);

	bfpl_first u_first_ovd (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.ocr_state (ocr_st),
		.oth_state (ovd_st),
		.first     (first_ovd)
	);

	// Outputs: gates, bias and standby from the settled states
	always_comb begin
		fault_next    = '{over_charge: ovc_st, over_discharge: ovd_st, over_current: ocr_st,
		                  short_circuit: scd_st, excess_charger: xch_st};
		ovc_seen_next = ovc_seen_reg;
		if (ovc_st) begin
			ovc_seen_next = 1'b1;
		end else if (!ovd_st) begin
			ovc_seen_next = 1'b0;
		end
		// Discharge FET off on over-current or short; over-discharge also opens it
		dis_gate_next = !(ocr_st || scd_st || ovd_st);
		// Charge FET off on over-charge or excessive charger
		chg_gate_next = !(xch_st || ovc_st);
		bias_next     = BFPL_BIAS_OPEN;
		standby_next  = 1'b0;
		if (ovd_st) begin
			// Supply pull-up replaces any ground pull
			bias_next    = BFPL_BIAS_SUP;
			// Standby only if no over-charge preceded it; this keeps load detection alive
			standby_next = !ovc_seen_reg && !ovc_st;
		end else if (scd_st || (ocr_st && !(ovc_st && first_ovc == BFPL_FIRST_OTHR))) begin
			bias_next = BFPL_BIAS_GND;
		end else begin
			bias_next = BFPL_BIAS_OPEN;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			fault_reg    <= '0;
			dis_gate_reg <= 1'b1;
			chg_gate_reg <= 1'b1;
			bias_reg     <= BFPL_BIAS_OPEN;
			standby_reg  <= 1'b0;
			ovc_seen_reg <= 1'b0;
		end else begin
			fault_reg    <= fault_next;
			dis_gate_reg <= dis_gate_next;
			chg_gate_reg <= chg_gate_next;
			bias_reg     <= bias_next;
			standby_reg  <= standby_next;
			ovc_seen_reg <= ovc_seen_next;
		end
	end

	assign fault      = fault_reg;
	assign dis_gate   = dis_gate_reg;
	assign chg_gate   = chg_gate_reg;
	assign sense_bias = bias_reg;
	assign standby    = standby_reg;
endmodule : bfpl_core

// ---- testbench/bfpl_core_props.sv ----
// Port assertions for the fault priority core
`timescale 1ns/10ps
module bfpl_core_props
	import bfpl_pkg::*;
(
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  bfpl_pkg::bfpl_state_t fault,
	input  wire logic             dis_gate,
	input  wire logic             chg_gate,
	input  bfpl_pkg::bfpl_bias_t  sense_bias,
	input  wire logic             standby
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	// Gate outputs and fault flags leave the same register stage
	a_dis_gate_off: assert property ((fault.over_current || fault.short_circuit) |-> !dis_gate)
		else $error("discharge gate on during current fault");
	a_chg_gate_off: assert property (fault.excess_charger |-> !chg_gate)
		else $error("charge gate on during excess charger");
	a_xch_inhibit: assert property ($rose(fault.excess_charger) |->
		!(fault.over_discharge || fault.over_current || fault.short_circuit))
		else $error("excess charger set while inhibited");
	// Count may only run once the discharge gate is back on
	a_xch_after_dis: assert property ($rose(fault.excess_charger) |->
		$past(dis_gate) && $past(dis_gate, 2))
		else $error("excess charger set too soon after discharge gate");
	a_bias_ground: assert property (fault.over_current && !fault.over_discharge |->
		sense_bias == BFPL_BIAS_GND)
		else $error("sense node not pulled to ground");
	a_bias_supply: assert property (fault.over_discharge |-> sense_bias == BFPL_BIAS_SUP)
		else $error("sense node not pulled to supply");
	a_no_standby: assert property (fault.over_charge && fault.over_discharge |-> !standby)
		else $error("standby entered after over-charge");
	a_ocr_order: assert property ($rose(fault.over_current) |->
		!$past(fault.over_charge) && !$past(fault.over_discharge))
		else $error("over-current set after another state");

	c_standby: cover property (standby);
	c_both: cover property (fault.over_charge && fault.over_discharge);
	c_xch: cover property (fault.excess_charger);
endmodule : bfpl_core_props

// ---- testbench/bfpl_fet_model.sv ----
// Behavioural model of the external charge and discharge switches
`timescale 1ns/10ps
module bfpl_fet_model (
	input  wire logic sys_clk,
	input  wire logic dis_gate,
	input  wire logic chg_gate,
	output logic      dis_on,
	output logic      chg_on
);
	// Switches settle one cycle after the gate moves
	always_ff @(posedge sys_clk) begin
		dis_on <= dis_gate;
		chg_on <= chg_gate;
	end
endmodule : bfpl_fet_model

// ---- testbench/tb.sv ----
// Scenario testbench for the fault priority core
`timescale 1ns/10ps
module tb;
	import bfpl_pkg::*;
	// Short delays keep each scenario to a few dozen cycles
	localparam logic [15:0] D = 16'h0004;
	logic        sys_clk, rst, dis_gate, chg_gate, standby, dis_on, chg_on;
	bfpl_cmp_t   cmp;
	bfpl_state_t fault;
	bfpl_bias_t  sense_bias;
	int          error_cnt, tests_run;

	bfpl_core #(.OVC_DLY(D), .OVD_DLY(D), .OCR_DLY(D), .SCD_DLY(D), .XCH_DLY(D), .REL_DLY(D)) bfpl_core_inst (
		.sys_clk(sys_clk), .rst(rst), .cmp(cmp), .fault(fault), .dis_gate(dis_gate),
		.chg_gate(chg_gate), .sense_bias(sense_bias), .standby(standby));
	bfpl_fet_model bfpl_fet_model_inst (.sys_clk(sys_clk), .dis_gate(dis_gate), .chg_gate(chg_gate),
		.dis_on(dis_on), .chg_on(chg_on));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic run(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : run
	task automatic chk(input logic [4:0] got, input logic [4:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Short reset between scenarios clears every held state
	task automatic restart();
		cmp = '0;
		rst = 1'b1;
		run(2);
		rst = 1'b0;
	endtask : restart
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : summarize

	task automatic ocr_then_ovc();
		restart();
		cmp = 5'h04;
		run(7);
		chk({dis_gate, chg_gate, sense_bias}, {2'b01, BFPL_BIAS_GND});
		cmp = 5'h14;
		run(7);
		chk(fault, 5'h14);
		chk(sense_bias, BFPL_BIAS_GND);
		chk({dis_on, chg_on}, 2'b00);
	endtask : ocr_then_ovc
	task automatic ovc_then_ocr();
		restart();
		cmp = 5'h10;
		run(7);
		cmp = 5'h14;
		run(12);
		chk(fault, 5'h10);
		chk(sense_bias, BFPL_BIAS_OPEN);
	endtask : ovc_then_ocr
	task automatic ocr_then_ovd();
		restart();
		cmp = 5'h04;
		run(7);
		cmp = 5'h0C;
		run(7);
		chk(fault, 5'h0C);
		chk({standby, sense_bias}, {1'b1, BFPL_BIAS_SUP});
	endtask : ocr_then_ovd
	task automatic ovd_then_others();
		restart();
		cmp = 5'h08;
		run(7);
		cmp = 5'h0D;
		run(12);
		chk(fault, 5'h08);
		chk({standby, sense_bias}, {1'b1, BFPL_BIAS_SUP});
		cmp = 5'h0F;
		run(7);
		chk(fault, 5'h0A);
	endtask : ovd_then_others
	// Over-discharge count must freeze while over-charge qualifies
	task automatic ovc_with_ovd();
		restart();
		cmp = 5'h18;
		run(6);
		chk(fault, 5'h10);
		run(6);
		chk(fault, 5'h18);
		chk({standby, sense_bias}, {1'b0, BFPL_BIAS_SUP});
	endtask : ovc_with_ovd
	task automatic xch_after_dis();
		restart();
		cmp = 5'h04;
		run(6);
		cmp = 5'h05;
		run(8);
		chk(chg_gate, 1'b1);
		cmp = 5'h01;
		run(9);
		chk({dis_gate, chg_gate}, 2'b11);
		run(1);
		chk({dis_gate, chg_gate}, 2'b10);
		run(1);
		chk({dis_on, chg_on}, 2'b10);
		cmp = 5'h00;
		run(7);
		chk(chg_gate, 1'b1);
	endtask : xch_after_dis

	initial begin
		rst = 1'b1;
		cmp = '0;
		error_cnt = 0;
		tests_run = 0;
		run(12);
		rst = 1'b0;
		run(1);
		chk(fault, 5'h00);
		chk({dis_gate, chg_gate, sense_bias}, {2'b11, BFPL_BIAS_OPEN});
		ocr_then_ovc();
		ovc_then_ocr();
		ocr_then_ovd();
		ovd_then_others();
		ovc_with_ovd();
		xch_after_dis();
		summarize();
	end
endmodule : tb

bind bfpl_core bfpl_core_props bfpl_core_props_inst (.sys_clk(sys_clk), .rst(rst), .fault(fault),
	.dis_gate(dis_gate), .chg_gate(chg_gate), .sense_bias(sense_bias), .standby(standby));
